// *** twep_pkg.sv ***
package twep_pkg;

    // ------------------------------------------------------------
    // Instruction framing
    // ------------------------------------------------------------
    localparam logic START_BIT = 1'b1;
    localparam int OPC_W = 2;
    localparam int WORD_W = 16;
    localparam int ADDR_W_DEF = 6;
    localparam int MAX_ADDR_W = 10;
    localparam int LARGE_ADDR_W = 10;

    localparam logic [1:0] OPC_READ = 2'h2;
    localparam logic [1:0] OPC_ERASE = 2'h3;
    localparam logic [1:0] OPC_WRITE = 2'h1;
    localparam logic [1:0] OPC_EXT = 2'h0;
    localparam logic [1:0] EXT_ENABLE = 2'h3;
    localparam logic [1:0] EXT_DISABLE = 2'h0;
    localparam logic [1:0] EXT_CLEAR_ALL = 2'h2;
    localparam logic [1:0] EXT_WRITE_ALL = 2'h1;

    // ------------------------------------------------------------
    // Data and pin levels
    // ------------------------------------------------------------
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;
    localparam logic DUMMY_BIT = 1'b0;
    localparam logic BUSY_LEVEL = 1'b0;
    localparam logic READY_LEVEL = 1'b1;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int MIN_DESELECT_TIME_NS = 250;
    localparam int PROGRAM_CYCLE_TIME_NS = 10_000_000;
    // Round down to stay inside the limit
    localparam int PROG_CYCLES = PROGRAM_CYCLE_TIME_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CMD_NONE = 3'h0,
        CMD_READ = 3'h1,
        CMD_ERASE = 3'h2,
        CMD_WRITE = 3'h3,
        CMD_PROGRAM_ENABLE = 3'h4,
        CMD_PROGRAM_DISABLE = 3'h5,
        CMD_CLEAR_ALL = 3'h6,
        CMD_WRITE_ALL = 3'h7
    } twep_kind_t;

    typedef struct packed {
        twep_kind_t kind;
        logic [MAX_ADDR_W-1:0] addr;
        logic [WORD_W-1:0] data;
    } twep_cmd_t;

    typedef enum logic [1:0] {
        PRG_IDLE = 2'h0,
        PRG_CLEAR = 2'h1,
        PRG_STORE = 2'h2,
        PRG_WAIT = 2'h3
    } twep_prg_t;

endpackage

// *** twep_sync.sv ***
`timescale 1ns/100ps
`default_nettype none

module twep_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Levels from another domain
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    // ------------------------------------------------------------
    // Two-stage synchroniser; the first stage feeds only the second
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule // twep_sync

`default_nettype wire

// *** twep_port.sv ***
// Behaviour
// [RULE1] Instruction is start bit one, 2-bit opcode, address, data for writes.
// [RULE2] Header is 9, 11 or 13 bits with 6, 8 or 10 address bits.
// [RULE3] Input bits are sampled on each rising serial clock edge.
// [RULE4] Output is released except for read data or program status.
// [RULE5] With select high after programming, output low busy, high ready.
// [RULE6] A one shifted in releases status output at next falling clock edge.
// [RULE7] Read sends one dummy zero, then the word MSB first.
// [RULE8] Read output bits change on the rising serial clock edge.
// [RULE9] Write data is stored by a clear-then-store cycle started at deselect.
// [RULE10] Self-timed cycle completes without any further serial clock.
// [RULE11] Single-word write clears the word itself before storing.
// [RULE12] Erase clears the addressed word to all ones at deselect.
// [RULE13] Write-enable latch is clear after reset; programming refused until enabled.
// [RULE14] Write-enable latch stays set until reset or disable instruction.
// [RULE15] Latch clear: write, erase, write-all, clear-all leave memory unchanged.
// [RULE16] Reads work whatever the write-enable latch holds.
// [RULE17] Clear-all sets every bit of every word to one at deselect.
// [RULE18] Write-all stores its data to every word, no erase needed.
// [RULE19] On the largest size programming needs program enable input high.
// [RULE20] Each program cycle ends within 10 ms, then status shows ready.
// [RULE21] On 2048-bit size the top address bit is ignored.
// [RULE22] Opcodes: read 10, erase 11, write 01; 00 uses two top address bits.
`timescale 1ns/100ps
`default_nettype none

module twep_port #(
    parameter int ADDR_W = twep_pkg::ADDR_W_DEF,
    parameter int ADDR_USED = twep_pkg::ADDR_W_DEF,
    parameter int PROG_CYCLES = twep_pkg::PROG_CYCLES
) (
    // System clock and reset
    input wire logic clk,
    input wire logic reset,
    // Serial link pins
    input wire logic chip_select,
    input wire logic serial_shift_clock,
    input wire logic serial_data_in,
    input wire logic program_enable_input,
    output logic serial_data_out,
    output logic serial_data_out_en,
    // Status
    output logic busy
);

    localparam int MAXA = twep_pkg::MAX_ADDR_W;
    localparam int WW = twep_pkg::WORD_W;
    localparam int HDR_W = twep_pkg::OPC_W + ADDR_W;
    localparam int SH_W = HDR_W + WW;
    localparam int WORDS = 1 << ADDR_USED;
    localparam int TMR_W = $clog2(PROG_CYCLES + 1);
    localparam logic [5:0] HDR_LAST = 6'(HDR_W - 1);
    localparam logic [5:0] SH_LAST = 6'(SH_W - 1);
    localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(PROG_CYCLES - 1);
    localparam logic [ADDR_USED-1:0] IDX_LAST = ADDR_USED'(WORDS - 1);
    localparam bit PE_USED = (ADDR_W == twep_pkg::LARGE_ADDR_W);

    // ------------------------------------------------------------
    // Decode helper
    // ------------------------------------------------------------
    function automatic twep_pkg::twep_kind_t decode_kind(input logic [1:0] opc, input logic [1:0] top);
        twep_pkg::twep_kind_t k;
        k = twep_pkg::CMD_NONE;
        case (opc)
            twep_pkg::OPC_READ: k = twep_pkg::CMD_READ;
            twep_pkg::OPC_ERASE: k = twep_pkg::CMD_ERASE;
            twep_pkg::OPC_WRITE: k = twep_pkg::CMD_WRITE;
            default: begin
                case (top)
                    twep_pkg::EXT_ENABLE: k = twep_pkg::CMD_PROGRAM_ENABLE;
                    twep_pkg::EXT_DISABLE: k = twep_pkg::CMD_PROGRAM_DISABLE;
                    twep_pkg::EXT_CLEAR_ALL: k = twep_pkg::CMD_CLEAR_ALL;
                    default: k = twep_pkg::CMD_WRITE_ALL;
                endcase
            end
        endcase
        return k;
    endfunction

    // ------------------------------------------------------------
    // Storage array
    // ------------------------------------------------------------
    logic [WW-1:0] mem [WORDS];

    // ------------------------------------------------------------
    // Link domain: instruction shifter
    // ------------------------------------------------------------
    // Serial clock domain; select low clears
    // frame state since the clock may stop.
    logic started_q;
    logic done_q;
    logic [5:0] cnt_q;
    logic [SH_W-1:0] sh_q;
    logic rd_oe_q;
    logic rd_bit_q;
    logic rd_load_q;
    logic [4:0] rd_cnt_q;
    logic [WW-1:0] rd_sh_q;
    logic release_q;
    logic pend_q;
    twep_pkg::twep_cmd_t cmd_q;

    wire logic shifting = started_q && !done_q;
    wire logic [SH_W-1:0] sh_d = {sh_q[SH_W-2:0], serial_data_in}; // see [RULE3]
    wire logic hdr_end = shifting && (cnt_q == HDR_LAST); // see [RULE2]
    wire logic data_end = shifting && (cnt_q == SH_LAST);
    wire logic [1:0] hdr_opc = sh_d[HDR_W-1 -: 2];
    wire logic [ADDR_W-1:0] hdr_addr = sh_d[ADDR_W-1:0];
    wire twep_pkg::twep_kind_t hdr_kind = decode_kind(hdr_opc, hdr_addr[ADDR_W-1 -: 2]); // see [RULE22]
    wire logic hdr_has_data = (hdr_kind == twep_pkg::CMD_WRITE) || (hdr_kind == twep_pkg::CMD_WRITE_ALL);
    wire logic [1:0] full_opc = sh_d[SH_W-1 -: 2];
    wire logic [ADDR_W-1:0] full_addr = sh_d[WW +: ADDR_W];
    wire twep_pkg::twep_kind_t full_kind = decode_kind(full_opc, full_addr[ADDR_W-1 -: 2]);
    wire logic hdr_done = hdr_end && !hdr_has_data;
    // Unused top address bits ignored
    wire logic [ADDR_USED-1:0] rd_idx = cmd_q.addr[ADDR_USED-1:0]; // see [RULE21]
    // Quasi-static read: address held,
    // array written only while busy.
    wire logic [WW-1:0] rd_word = mem[rd_idx];

    // Frame progress
    always_ff @(posedge serial_shift_clock or negedge chip_select) begin
        if (!chip_select) begin
            started_q <= 1'b0;
            done_q <= 1'b0;
            cnt_q <= 6'h00;
            sh_q <= '0;
        end else begin
            if (!started_q) begin
                started_q <= (serial_data_in == twep_pkg::START_BIT); // see [RULE1]
            end
            if (shifting) begin
                cnt_q <= cnt_q + 6'h01;
                sh_q <= sh_d;
            end
            if (hdr_done || data_end) begin
                done_q <= 1'b1;
            end
        end
    end

    // Read output shifter
    always_ff @(posedge serial_shift_clock or negedge chip_select) begin
        if (!chip_select) begin
            rd_oe_q <= 1'b0;
            rd_bit_q <= 1'b0;
            rd_load_q <= 1'b0;
            rd_cnt_q <= 5'h00;
            rd_sh_q <= '0;
        end else if (hdr_end && hdr_kind == twep_pkg::CMD_READ) begin
            rd_oe_q <= 1'b1; // see [RULE16]
            rd_bit_q <= twep_pkg::DUMMY_BIT; // see [RULE7]
            rd_load_q <= 1'b1;
        end else if (rd_load_q) begin
            rd_load_q <= 1'b0;
            rd_bit_q <= rd_word[WW-1]; // see [RULE7]
            rd_sh_q <= {rd_word[WW-2:0], 1'b0};
            rd_cnt_q <= 5'(WW - 1);
        end else if (rd_oe_q) begin
            rd_bit_q <= rd_sh_q[WW-1]; // see [RULE8]
            rd_sh_q <= {rd_sh_q[WW-2:0], 1'b0};
            rd_cnt_q <= rd_cnt_q - 5'h01;
            rd_oe_q <= (rd_cnt_q != 5'h00); // see [RULE4]
        end
    end

    // Any start bit releases status
    always_ff @(negedge serial_shift_clock or negedge chip_select) begin
        if (!chip_select) begin
            release_q <= 1'b0;
        end else begin
            release_q <= started_q; // see [RULE6]
        end
    end

    // Latched instruction survives deselect
    always_ff @(posedge serial_shift_clock or posedge reset) begin
        if (reset) begin
            pend_q <= 1'b0;
            cmd_q <= '0;
        end else begin
            if (!started_q && serial_data_in == twep_pkg::START_BIT) begin
                pend_q <= 1'b0;
            end else if (hdr_done || data_end) begin
                pend_q <= 1'b1;
            end
            if (hdr_end) begin
                cmd_q.kind <= hdr_kind;
                cmd_q.addr <= MAXA'(hdr_addr);
            end else if (data_end) begin
                cmd_q.kind <= full_kind;
                cmd_q.addr <= MAXA'(full_addr);
                cmd_q.data <= sh_d[WW-1:0]; // see [RULE1]
            end
        end
    end

    // ------------------------------------------------------------
    // Crossing into the system clock
    // ------------------------------------------------------------
    logic [5:0] sync_s;
    wire logic sel_s = sync_s[0];
    wire logic pend_s = sync_s[1];
    wire logic rd_oe_s = sync_s[2];
    wire logic rd_bit_s = sync_s[3];
    wire logic release_s = sync_s[4];
    wire logic pe_s = sync_s[5];

    twep_sync #(
        .WIDTH(6)
    ) u_sync (
        .clk(clk),
        .reset(reset),
        .async_in({program_enable_input, release_q, rd_bit_q, rd_oe_q, pend_q, chip_select}),
        .sync_out(sync_s)
    );

    // ------------------------------------------------------------
    // System domain: deselect handling and write-enable latch
    // ------------------------------------------------------------
    logic sel_prev_q;
    logic wen_q;
    logic stat_arm_q;
    twep_pkg::twep_prg_t state_q;
    twep_pkg::twep_prg_t state_d;
    twep_pkg::twep_kind_t kind_q;
    logic [ADDR_USED-1:0] idx_q;
    logic [ADDR_USED-1:0] idx_d;
    logic [ADDR_USED-1:0] base_q;
    logic [WW-1:0] data_q;
    logic [TMR_W-1:0] tmr_q;

    wire logic idle = (state_q == twep_pkg::PRG_IDLE);
    // Pend and select share one synchroniser
    wire logic desel = sel_prev_q && !sel_s && pend_s && idle; // see [RULE9]
    wire twep_pkg::twep_kind_t pkind = cmd_q.kind;
    wire logic is_prog = (pkind == twep_pkg::CMD_ERASE) || (pkind == twep_pkg::CMD_WRITE)
        || (pkind == twep_pkg::CMD_CLEAR_ALL) || (pkind == twep_pkg::CMD_WRITE_ALL);
    // A floating pin is pulled high outside
    wire logic pe_ok = !PE_USED || pe_s; // see [RULE19]
    wire logic start = desel && is_prog && wen_q && pe_ok; // see [RULE15]
    wire logic is_all = (kind_q == twep_pkg::CMD_CLEAR_ALL) || (kind_q == twep_pkg::CMD_WRITE_ALL);
    wire logic idx_end = !is_all || (idx_q == IDX_LAST);
    wire logic tmr_end = (tmr_q == TMR_LAST); // see [RULE20]
    wire logic mem_we = (state_q == twep_pkg::PRG_CLEAR) || (state_q == twep_pkg::PRG_STORE);
    wire logic [WW-1:0] mem_wd = (state_q == twep_pkg::PRG_CLEAR) ? twep_pkg::ERASED_WORD : data_q; // see [RULE12]
    wire logic [ADDR_USED-1:0] start_idx = is_all ? '0 : base_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            sel_prev_q <= 1'b0;
            wen_q <= 1'b0; // see [RULE13]
        end else begin
            sel_prev_q <= sel_s;
            if (desel && pkind == twep_pkg::CMD_PROGRAM_ENABLE) begin
                wen_q <= 1'b1; // see [RULE14]
            end else if (desel && pkind == twep_pkg::CMD_PROGRAM_DISABLE) begin
                wen_q <= 1'b0; // see [RULE14]
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            kind_q <= twep_pkg::CMD_NONE;
            base_q <= '0;
            data_q <= '0;
        end else if (start) begin
            kind_q <= pkind;
            base_q <= cmd_q.addr[ADDR_USED-1:0]; // see [RULE21]
            data_q <= cmd_q.data;
        end
    end

    // ------------------------------------------------------------
    // Self-timed program sequencer
    // ------------------------------------------------------------
    // System clock only; the serial clock may stop
    always_comb begin
        state_d = state_q;
        idx_d = idx_q;
        case (state_q)
            twep_pkg::PRG_IDLE: begin
                if (start) begin
                    // Write-all needs no clear pass
                    state_d = (pkind == twep_pkg::CMD_WRITE_ALL) ? twep_pkg::PRG_STORE : twep_pkg::PRG_CLEAR; // see [RULE18]
                    idx_d = (pkind == twep_pkg::CMD_ERASE || pkind == twep_pkg::CMD_WRITE)
                        ? cmd_q.addr[ADDR_USED-1:0] : '0;
                end
            end
            twep_pkg::PRG_CLEAR: begin
                if (!idx_end) begin
                    idx_d = idx_q + 1'b1; // see [RULE17]
                end else if (kind_q == twep_pkg::CMD_WRITE) begin
                    state_d = twep_pkg::PRG_STORE; // see [RULE11]
                    idx_d = start_idx;
                end else begin
                    state_d = twep_pkg::PRG_WAIT;
                end
            end
            twep_pkg::PRG_STORE: begin
                if (!idx_end) begin
                    idx_d = idx_q + 1'b1; // see [RULE18]
                end else begin
                    state_d = twep_pkg::PRG_WAIT;
                end
            end
            twep_pkg::PRG_WAIT: begin
                if (tmr_end) begin
                    state_d = twep_pkg::PRG_IDLE; // see [RULE10]
                end
            end
            default: begin
                state_d = twep_pkg::PRG_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= twep_pkg::PRG_IDLE;
            idx_q <= '0;
            tmr_q <= '0;
        end else begin
            state_q <= state_d;
            idx_q <= idx_d;
            tmr_q <= idle ? '0 : tmr_q + 1'b1; // see [RULE20]
        end
    end

    // Contents survive reset
    always_ff @(posedge clk) begin
        if (mem_we) begin
            mem[idx_q] <= mem_wd; // see [RULE9]
        end
    end

    // ------------------------------------------------------------
    // Output pin and status
    // ------------------------------------------------------------
    // Status armed until a frame ends while ready
    wire logic stat_show = sel_s && stat_arm_q && !release_s && !rd_oe_s; // see [RULE6]
    wire logic prog_busy = !idle || start;

    always_ff @(posedge clk) begin
        if (reset) begin
            stat_arm_q <= 1'b0;
        end else if (start) begin
            stat_arm_q <= 1'b1;
        end else if (sel_prev_q && !sel_s && idle) begin
            stat_arm_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            serial_data_out <= twep_pkg::READY_LEVEL;
            serial_data_out_en <= 1'b0;
            busy <= 1'b0;
        end else begin
            serial_data_out <= rd_oe_s ? rd_bit_s
                : (prog_busy ? twep_pkg::BUSY_LEVEL : twep_pkg::READY_LEVEL); // see [RULE5]
            serial_data_out_en <= rd_oe_s || stat_show; // see [RULE4]
            busy <= prog_busy;
        end
    end

endmodule // twep_port

`default_nettype wire

// *** twep_port_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none

module twep_port_checker #(
    parameter int PROG_CYCLES = twep_pkg::PROG_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Link pins
    input wire logic chip_select,
    input wire logic serial_shift_clock,
    input wire logic serial_data_in,
    input wire logic program_enable_input,
    input wire logic serial_data_out,
    input wire logic serial_data_out_en,
    // Status
    input wire logic busy
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    logic [31:0] busy_cnt_q;
    always_ff @(posedge clk) begin
        if (reset) begin
            busy_cnt_q <= 32'h0;
        end else begin
            busy_cnt_q <= busy ? busy_cnt_q + 32'h1 : 32'h0;
        end
    end

    // --------------------------------------------------------
    // Properties
    // --------------------------------------------------------
    sequence s_deselected;
        !chip_select [*5];
    endsequence
    sequence s_status_poll;
        busy && $past(busy) && chip_select && serial_data_out_en;
    endsequence
    sequence s_ready_poll;
        $fell(busy) && chip_select ##1 chip_select [*4];
    endsequence

    property p_idle_release;
        s_deselected |-> !serial_data_out_en;
    endproperty
    property p_reset_quiet;
        $fell(reset) |-> !busy && !serial_data_out_en;
    endproperty
    property p_start_on_deselect;
        $rose(busy) |-> !$past(chip_select) && !$past(chip_select, 2);
    endproperty
    property p_busy_status;
        s_status_poll |-> serial_data_out == twep_pkg::BUSY_LEVEL;
    endproperty
    property p_ready_status;
        s_ready_poll |-> serial_data_out == twep_pkg::READY_LEVEL || !serial_data_out_en;
    endproperty
    property p_cycle_bound;
        busy |-> busy_cnt_q <= PROG_CYCLES;
    endproperty
    property p_cycle_length;
        $fell(busy) |-> busy_cnt_q >= PROG_CYCLES - 1;
    endproperty
    property p_busy_hold;
        $rose(busy) |-> busy [*4];
    endproperty
    property p_read_on_sck;
        $changed(serial_data_out) && serial_data_out_en && $past(serial_data_out_en) && !busy && !$past(busy)
            && !$past(busy, 2) && !$past(busy, 3) && !$past(busy, 4)
            |-> $past(serial_shift_clock, 2) || $past(serial_shift_clock, 3);
    endproperty

    a_idle_release: assert property (p_idle_release) else $error("driven while idle");
    a_reset_quiet: assert property (p_reset_quiet) else $error("activity after reset");
    a_start_on_deselect: assert property (p_start_on_deselect) else $error("started while selected");
    a_busy_status: assert property (p_busy_status) else $error("busy not low");
    a_ready_status: assert property (p_ready_status) else $error("ready not high");
    a_cycle_bound: assert property (p_cycle_bound) else $error("pass too long");
    a_cycle_length: assert property (p_cycle_length) else $error("pass too short");
    a_busy_hold: assert property (p_busy_hold) else $error("pass cut short");
    a_read_on_sck: assert property (p_read_on_sck) else $error("read bit off clock edge");
endmodule // twep_port_checker

bind twep_port twep_port_checker #(.PROG_CYCLES(PROG_CYCLES)) i_twep_port_checker (
    .clk(clk),
    .reset(reset),
    .chip_select(chip_select),
    .serial_shift_clock(serial_shift_clock),
    .serial_data_in(serial_data_in),
    .program_enable_input(program_enable_input),
    .serial_data_out(serial_data_out),
    .serial_data_out_en(serial_data_out_en),
    .busy(busy)
);

`default_nettype wire

// *** twep_host.sv ***
`timescale 1ns/100ps
`default_nettype none

module twep_host (
    // Link pins toward the device
    output logic chip_select,
    output logic serial_shift_clock,
    output logic serial_data_in,
    // Pins from the device
    input wire logic serial_data_out,
    input wire logic serial_data_out_en,
    // Output captured in the last frame
    output logic [16:0] rd_word,
    output logic rd_tick
);
    wire logic dout_pin;
    assign dout_pin = serial_data_out_en ? serial_data_out : 1'bz;

    initial begin
        chip_select = 1'b0;
        serial_shift_clock = 1'b0;
        serial_data_in = 1'b0;
        rd_word = 17'h0;
        rd_tick = 1'b0;
    end

    task automatic open_frame();
        #3 chip_select = 1'b1;
        #40;
    endtask

    task automatic shift_bits(input logic [47:0] bits, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            serial_data_in = bits[i];
            #15 serial_shift_clock = 1'b1;
            #15 serial_shift_clock = 1'b0;
            rd_word = {rd_word[15:0], dout_pin};
        end
    endtask

    task automatic close_frame(input logic read);
        #10 chip_select = 1'b0;
        serial_data_in = ~serial_data_in;
        if (read) begin
            rd_tick = 1'b1;
            #1 rd_tick = 1'b0;
        end
        #300;
    endtask
endmodule // twep_host

`default_nettype wire

// *** twep_port_bench.sv ***
`timescale 1ns/100ps
`default_nettype none

`define CHECK(got, exp, what) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) begin \
            num_errors++; \
            $display("CHECK FAILED %s expected %h seen %h", what, (exp), (got)); \
        end \
    end

module twep_port_bench;
    logic clk = 1'b0;
    logic reset;
    logic program_enable_input;
    logic chip_select;
    logic serial_shift_clock;
    logic serial_data_in;
    logic serial_data_out;
    logic serial_data_out_en;
    logic busy;
    logic [16:0] rd_word;
    logic rd_tick;
    logic [16:0] exp_q[$];
    logic [16:0] exp_w;
    logic [5:0] addr;
    logic [15:0] data;
    int num_errors = 0;
    int checks_done = 0;

    always #4 clk = ~clk;

    twep_port #(.ADDR_W(6), .ADDR_USED(6), .PROG_CYCLES(200)) i_twep_port (
        .clk(clk),
        .reset(reset),
        .chip_select(chip_select),
        .serial_shift_clock(serial_shift_clock),
        .serial_data_in(serial_data_in),
        .program_enable_input(program_enable_input),
        .serial_data_out(serial_data_out),
        .serial_data_out_en(serial_data_out_en),
        .busy(busy)
    );

    twep_host i_twep_host (
        .chip_select(chip_select),
        .serial_shift_clock(serial_shift_clock),
        .serial_data_in(serial_data_in),
        .serial_data_out(serial_data_out),
        .serial_data_out_en(serial_data_out_en),
        .rd_word(rd_word),
        .rd_tick(rd_tick)
    );

    // --------------------------------------------------------
    // Result monitor
    // --------------------------------------------------------
    always @(posedge rd_tick) begin
        if (exp_q.size() == 0) begin
            num_errors++;
            $display("CHECK FAILED read word expected none seen %h", rd_word);
        end else begin
            exp_w = exp_q.pop_front();
            `CHECK(rd_word, exp_w, "read word")
        end
    end

    // --------------------------------------------------------
    // Tasks
    // --------------------------------------------------------
    task automatic send(input logic [1:0] opc, input logic [5:0] a, input logic [15:0] d, input logic with_data);
        logic [47:0] b;
        b = {23'h0, twep_pkg::START_BIT, opc, a, d};
        i_twep_host.open_frame();
        if (with_data) begin
            i_twep_host.shift_bits(b, 25);
        end else begin
            i_twep_host.shift_bits(b >> 16, 9);
        end
        i_twep_host.close_frame(1'b0);
    endtask

    task automatic read_word(input logic [5:0] a, input logic [15:0] d);
        exp_q.push_back({twep_pkg::DUMMY_BIT, d});
        i_twep_host.open_frame();
        i_twep_host.shift_bits({22'h0, twep_pkg::START_BIT, twep_pkg::OPC_READ, a, 17'h0}, 26);
        i_twep_host.close_frame(1'b1);
    endtask

    task automatic refuse_all(input logic [5:0] a);
        logic [1:0] opc [4];
        logic [5:0] adr [4];
        opc = '{twep_pkg::OPC_WRITE, twep_pkg::OPC_ERASE, twep_pkg::OPC_EXT, twep_pkg::OPC_EXT};
        adr = '{a, a, {twep_pkg::EXT_CLEAR_ALL, 4'h0}, {twep_pkg::EXT_WRITE_ALL, 4'h0}};
        for (int k = 0; k < 4; k++) begin
            send(opc[k], adr[k], ~data, k == 0 || k == 3);
            repeat (20) @(posedge clk);
            `CHECK(busy, 1'b0, "refused program")
        end
    endtask

    task automatic poll_ready();
        int k;
        i_twep_host.open_frame();
        repeat (6) @(posedge clk);
        `CHECK(serial_data_out_en, 1'b1, "status enable")
        `CHECK(serial_data_out, twep_pkg::BUSY_LEVEL, "busy status")
        k = 0;
        while (serial_data_out !== twep_pkg::READY_LEVEL && k < 400) begin
            @(posedge clk);
            k++;
        end
        `CHECK(serial_data_out, twep_pkg::READY_LEVEL, "ready status")
        `CHECK(busy, 1'b0, "busy after ready")
        i_twep_host.shift_bits(48'h1, 1);
        repeat (6) @(posedge clk);
        `CHECK(serial_data_out_en, 1'b0, "status release")
        i_twep_host.close_frame(1'b0);
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // --------------------------------------------------------
    // Sequence
    // --------------------------------------------------------
    initial begin
        reset <= 1'b1;
        data = 16'($urandom(14));
        program_enable_input <= 1'($urandom());
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
        refuse_all(6'h05);
        send(twep_pkg::OPC_EXT, {twep_pkg::EXT_ENABLE, 4'h0}, 16'h0000, 1'b0);
        send(twep_pkg::OPC_EXT, {twep_pkg::EXT_CLEAR_ALL, 4'h0}, 16'h0000, 1'b0);
        poll_ready();
        read_word(6'h3F, twep_pkg::ERASED_WORD);
        read_word(6'h05, twep_pkg::ERASED_WORD);
        addr = 6'($urandom());
        repeat (3) begin
            data = 16'($urandom());
            send(twep_pkg::OPC_WRITE, addr, data, 1'b1);
            poll_ready();
            read_word(addr, data);
        end
        send(twep_pkg::OPC_ERASE, addr, 16'h0000, 1'b0);
        poll_ready();
        read_word(addr, twep_pkg::ERASED_WORD);
        data = 16'($urandom());
        send(twep_pkg::OPC_EXT, {twep_pkg::EXT_WRITE_ALL, 4'h0}, data, 1'b1);
        poll_ready();
        read_word(6'h00, data);
        read_word(6'h3F, data);
        send(twep_pkg::OPC_EXT, {twep_pkg::EXT_DISABLE, 4'h0}, 16'h0000, 1'b0);
        refuse_all(addr);
        read_word(addr, data);
        repeat (10) @(posedge clk);
        give_verdict();
    end

    initial begin
        #400000;
        num_errors++;
        $display("CHECK FAILED watchdog expected finish seen hang");
        give_verdict();
    end
endmodule // twep_port_bench

`default_nettype wire
